// ===== core/ffrc_pkg.sv
/*
 * Shared constants and types of the FIFO reset and rewind controller.
 * Assumes one system clock of 100 MHz; all figures below are in that frame.
 */
package ffrc_pkg;

    localparam int FFRC_DATA_W      = 18;
    localparam int FFRC_ADDR_W      = 15;

    // threshold defaults chosen by the offset-access strap at master reset
    localparam int FFRC_OFF_DEF_PAR = 'h07F;
    localparam int FFRC_OFF_DEF_SER = 'h3FF;

    localparam int FFRC_CLK_NS      = 10;
    // length of the rewind setup window, a least time
    localparam int FFRC_REWIND_NS   = 20;
    localparam int FFRC_REWIND_RAW  = (FFRC_REWIND_NS + FFRC_CLK_NS - 1) / FFRC_CLK_NS;
    localparam int FFRC_REWIND_CYC  = (FFRC_REWIND_RAW < 1) ? 1 : FFRC_REWIND_RAW;
    localparam int FFRC_RWCNT_W     = 8;

    typedef enum logic [0:0] {
        FFRC_RUN,
        FFRC_REWIND
    } ffrc_state_t;

endpackage

// ===== core/ffrc_ctrl.sv
/*
 * FIFO store with master reset, partial reset, rewind, offset programming
 * and the status flags those operations drive.
 * Assumes writer and reader are logic on clk_in, so write and read clock
 * edges coincide with clk_in; master and partial reset are sampled pins
 * from that same logic and act on the next edge.
 */
// Chosen here: strobed register access, with the empty then the full offset taken in turn.
`timescale 1ns/1ps

module ffrc_ctrl
    import ffrc_pkg::*;
#(
    parameter int DATA_W = FFRC_DATA_W,
    parameter int ADDR_W = FFRC_ADDR_W
) (
    input  wire logic              clk_in,
    input  wire logic              srst_in,
    input  wire logic              master_reset_n_in,
    input  wire logic              partial_reset_n_in,
    input  wire logic              rewind_request_n_in,
    input  wire logic              write_en_n_in,
    input  wire logic              read_en_n_in,
    input  wire logic              offset_access_n_in,
    input  wire logic              serial_shift_enable_n_in,
    input  wire logic              mode_select_serial_in,
    input  wire logic [DATA_W-1:0] data_in,
    output logic      [DATA_W-1:0] data_out,
    output logic                   empty_flag_n_out,
    output logic                   full_flag_n_out,
    output logic                   almost_empty_n_out,
    output logic                   almost_full_n_out,
    output logic                   half_full_n_out,
    output logic                   fallthrough_mode_out
);

    localparam int                PTR_W   = ADDR_W + 1;
    localparam logic [PTR_W-1:0]  DEPTH   = PTR_W'(1) << ADDR_W;
    localparam logic [PTR_W-1:0]  HALF    = PTR_W'(1) << (ADDR_W - 1);
    localparam logic [ADDR_W-1:0] OFF_PAR = ADDR_W'(FFRC_OFF_DEF_PAR);
    localparam logic [ADDR_W-1:0] OFF_SER = ADDR_W'(FFRC_OFF_DEF_SER);
    localparam logic [FFRC_RWCNT_W-1:0] RW_CYC = FFRC_RWCNT_W'(FFRC_REWIND_CYC);
    localparam logic [FFRC_RWCNT_W-1:0] RW_ONE = FFRC_RWCNT_W'(1);
    localparam logic [PTR_W-1:0]  PTR_ONE = PTR_W'(1);

    typedef struct packed {
        ffrc_state_t              state;
        logic [FFRC_RWCNT_W-1:0]  rw_cnt;
        logic                     fallthrough_mode;
        logic                     serial_load;
        logic [PTR_W-1:0]         wptr;
        logic [PTR_W-1:0]         rptr;
        logic [PTR_W-1:0]         rptr_q1;
        logic [PTR_W-1:0]         rptr_s1;
        logic [PTR_W-1:0]         wptr_s1;
        logic [PTR_W-1:0]         wptr_s2;
        logic [ADDR_W-1:0]        empty_off;
        logic [ADDR_W-1:0]        full_off;
        logic                     wr_off_sel;
        logic                     rd_off_sel;
        logic [DATA_W-1:0]        dout;
        logic                     out_valid;
        logic                     ef_n;
        logic                     ff_n;
        logic                     pae_n;
        logic                     paf_n;
        logic                     hf_n;
    } ffrc_regs_t;

    ffrc_regs_t          r_q;
    ffrc_regs_t          r_d;
    logic [DATA_W-1:0]   mem [0:(1 << ADDR_W)-1];
    logic                wr_fire;
    logic                master_rst;
    logic [PTR_W-1:0]    rd_cnt;
    logic [PTR_W-1:0]    wr_cnt;
    logic [PTR_W-1:0]    wr_cnt_next;
    logic [2*ADDR_W-1:0] shift_reg;

    function automatic logic [PTR_W-1:0] occupancy(
        input logic [PTR_W-1:0] wp,
        input logic [PTR_W-1:0] rp
    );
        return wp - rp;
    endfunction

    function automatic logic [DATA_W-1:0] widen_off(input logic [ADDR_W-1:0] off);
        return DATA_W'(off);
    endfunction

    // the power-on reset behaves as a master reset, so straps are caught here too
    assign master_rst = srst_in | ~master_reset_n_in;

    always_comb begin
        r_d       = r_q;
        wr_fire   = 1'b0;
        shift_reg = {r_q.full_off, r_q.empty_off};

        // reader sees the write pointer two stages late, writer sees the read
        // pointer one stage late; both views are conservative
        rd_cnt    = occupancy(r_q.wptr_s2, r_q.rptr);
        wr_cnt    = occupancy(r_q.wptr, r_q.rptr_s1);

        r_d.wptr_s1 = r_q.wptr;
        r_d.wptr_s2 = r_q.wptr_s1;
        r_d.rptr_s1 = r_q.rptr;
        r_d.rptr_q1 = r_q.rptr;

        // write side: offset programming has priority over storing data
        if (!offset_access_n_in) begin
            if (!r_q.serial_load && !write_en_n_in) begin
                if (r_q.wr_off_sel) begin
                    r_d.full_off = data_in[ADDR_W-1:0];
                end else begin
                    r_d.empty_off = data_in[ADDR_W-1:0];
                end
                r_d.wr_off_sel = ~r_q.wr_off_sel;
            end else if (r_q.serial_load && !serial_shift_enable_n_in) begin
                // new bit enters at the top; after a full pass the first bit
                // sits in the empty offset LSB
                shift_reg     = {mode_select_serial_in, shift_reg[2*ADDR_W-1:1]};
                r_d.empty_off = shift_reg[ADDR_W-1:0];
                r_d.full_off  = shift_reg[2*ADDR_W-1:ADDR_W];
            end
        end else if (!write_en_n_in && wr_cnt != DEPTH) begin
            wr_fire  = 1'b1;
            r_d.wptr = r_q.wptr + PTR_ONE;
        end

        // read side
        case (r_q.state)
            FFRC_RUN: begin
                if (!rewind_request_n_in) begin
                    // host is expected to hold both enables high here
                    r_d.rptr      = '0;
                    r_d.state     = FFRC_REWIND;
                    r_d.rw_cnt    = RW_CYC;
                    r_d.out_valid = 1'b0;
                end else if (!offset_access_n_in && !read_en_n_in) begin
                    // readback overwrites the word on the outputs
                    r_d.dout       = r_q.rd_off_sel ? widen_off(r_q.full_off)
                                                    : widen_off(r_q.empty_off);
                    r_d.rd_off_sel = ~r_q.rd_off_sel;
                end else if (r_q.fallthrough_mode) begin
                    if (!r_q.out_valid || !read_en_n_in) begin
                        if (rd_cnt != '0) begin
                            // fall-through: no read enable needed for the head word
                            r_d.dout      = mem[r_q.rptr[ADDR_W-1:0]];
                            r_d.rptr      = r_q.rptr + PTR_ONE;
                            r_d.out_valid = 1'b1;
                        end else if (!read_en_n_in) begin
                            r_d.out_valid = 1'b0;
                        end
                    end
                end else if (!read_en_n_in && rd_cnt != '0) begin
                    r_d.dout = mem[r_q.rptr[ADDR_W-1:0]];
                    r_d.rptr = r_q.rptr + PTR_ONE;
                end
            end
            FFRC_REWIND: begin
                // reads are held off until the setup window closes
                r_d.rw_cnt = r_q.rw_cnt - RW_ONE;
                if (r_q.rw_cnt <= RW_ONE) begin
                    r_d.state = FFRC_RUN;
                end
            end
            default: begin
                r_d.state = FFRC_RUN;
            end
        endcase

        wr_cnt_next = occupancy(r_d.wptr, r_q.rptr_s1);

        // empty pin: empty flag in standard mode, output ready in fall-through
        if (r_q.fallthrough_mode) begin
            r_d.ef_n = ~r_d.out_valid;
        end else begin
            r_d.ef_n = (r_d.state == FFRC_RUN)
                     && (occupancy(r_q.wptr_s2, r_d.rptr) != '0);
        end

        // full pin: full flag in standard mode, input ready in fall-through;
        // in fall-through the output word is outside memory, giving one extra slot
        r_d.ff_n  = r_q.fallthrough_mode ? (wr_cnt_next == DEPTH) : (wr_cnt_next != DEPTH);

        // pointer copy one edge old gives the second-edge update
        r_d.pae_n = ~(occupancy(r_q.wptr_s2, r_q.rptr_q1) <= PTR_W'(r_q.empty_off));
        r_d.paf_n = ~(wr_cnt_next >= DEPTH - PTR_W'(r_q.full_off));
        // half-full uses the live pointers, so the setup edge moves it at once
        r_d.hf_n  = ~(occupancy(r_d.wptr, r_d.rptr) > HALF);

        if (master_rst) begin
            wr_fire         = 1'b0;
            r_d             = '0;
            r_d.state       = FFRC_RUN;
            r_d.fallthrough_mode        = mode_select_serial_in;
            r_d.serial_load = offset_access_n_in;
            r_d.empty_off   = offset_access_n_in ? OFF_SER : OFF_PAR;
            r_d.full_off    = offset_access_n_in ? OFF_SER : OFF_PAR;
            r_d.dout        = '0;
            r_d.pae_n       = 1'b0;
            r_d.paf_n       = 1'b1;
            r_d.hf_n        = 1'b1;
            r_d.ef_n        = mode_select_serial_in;
            r_d.ff_n        = ~mode_select_serial_in;
        end else if (!partial_reset_n_in) begin
            wr_fire       = 1'b0;
            r_d.state     = FFRC_RUN;
            r_d.rw_cnt    = '0;
            r_d.wptr      = '0;
            r_d.rptr      = '0;
            r_d.rptr_q1   = '0;
            r_d.rptr_s1   = '0;
            r_d.wptr_s1   = '0;
            r_d.wptr_s2   = '0;
            r_d.out_valid = 1'b0;
            r_d.dout      = '0;
            r_d.empty_off = r_q.empty_off;
            r_d.full_off  = r_q.full_off;
            r_d.pae_n     = 1'b0;
            r_d.paf_n     = 1'b1;
            r_d.hf_n      = 1'b1;
            r_d.ef_n      = r_q.fallthrough_mode;
            r_d.ff_n      = ~r_q.fallthrough_mode;
        end
    end

    always_ff @(posedge clk_in) begin
        r_q <= r_d;
    end

    // storage has no reset; pointers alone decide what is valid
    always_ff @(posedge clk_in) begin
        if (wr_fire) begin
            mem[r_q.wptr[ADDR_W-1:0]] <= data_in;
        end
    end

    assign data_out             = r_q.dout;
    assign empty_flag_n_out     = r_q.ef_n;
    assign full_flag_n_out      = r_q.ff_n;
    assign almost_empty_n_out   = r_q.pae_n;
    assign almost_full_n_out    = r_q.paf_n;
    assign half_full_n_out      = r_q.hf_n;
    assign fallthrough_mode_out = r_q.fallthrough_mode;

endmodule // ffrc_ctrl

// ===== dv/ffrc_chk.sv
/* assertion checker for the fifo reset and rewind controller
   assumes it is bound onto the controller's own ports */
`timescale 1ns/1ps
module ffrc_chk
    import ffrc_pkg::*;
#(parameter int DATA_W = FFRC_DATA_W) (
    input wire logic              clk_in,
    input wire logic              srst_in,
    input wire logic              master_reset_n_in,
    input wire logic              partial_reset_n_in,
    input wire logic              rewind_request_n_in,
    input wire logic              write_en_n_in,
    input wire logic              read_en_n_in,
    input wire logic              offset_access_n_in,
    input wire logic              serial_shift_enable_n_in,
    input wire logic              mode_select_serial_in,
    input wire logic [DATA_W-1:0] data_in,
    input wire logic [DATA_W-1:0] data_out,
    input wire logic              empty_flag_n_out,
    input wire logic              full_flag_n_out,
    input wire logic              almost_empty_n_out,
    input wire logic              almost_full_n_out,
    input wire logic              half_full_n_out,
    input wire logic              fallthrough_mode_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (srst_in);
    // a fresh request only; a held request inside setup is ignored
    sequence s_rw;
        !rewind_request_n_in && $past(rewind_request_n_in) && $past(rewind_request_n_in, 2)
        && $past(rewind_request_n_in, 3) && master_reset_n_in && partial_reset_n_in;
    endsequence
    // no write, read or offset change close enough to move the synced flag inputs
    sequence s_calm;
        write_en_n_in && $past(write_en_n_in) && $past(write_en_n_in, 2) && $past(read_en_n_in)
        && offset_access_n_in && (!fallthrough_mode_out || !$past(empty_flag_n_out));
    endsequence
    sequence s_quiet;
        write_en_n_in && master_reset_n_in && partial_reset_n_in && !srst_in;
    endsequence
    a_srst_flags: assert property ($past(srst_in) |-> !almost_empty_n_out
        && almost_full_n_out && half_full_n_out && data_out == '0) else $error("reset flags");
    a_srst_mode: assert property ($past(srst_in) |-> empty_flag_n_out == fallthrough_mode_out
        && full_flag_n_out != fallthrough_mode_out
        && fallthrough_mode_out == $past(mode_select_serial_in)) else $error("reset mode");
    a_mrs_flags: assert property (!master_reset_n_in |=> !almost_empty_n_out
        && almost_full_n_out && half_full_n_out && data_out == '0) else $error("mrs flags");
    a_prs_keep: assert property (!partial_reset_n_in && master_reset_n_in |=>
        $stable(fallthrough_mode_out) && data_out == '0 && !almost_empty_n_out && almost_full_n_out
        && half_full_n_out && empty_flag_n_out == fallthrough_mode_out
        && full_flag_n_out != fallthrough_mode_out) else $error("prs flags");
    a_mode_held: assert property (master_reset_n_in |=> $stable(fallthrough_mode_out))
        else $error("mode moved");
    a_rw_std: assert property (s_rw ##0 !fallthrough_mode_out |=> !empty_flag_n_out [*2])
        else $error("std rewind empty");
    a_rw_ft: assert property (s_rw ##0 fallthrough_mode_out |=> empty_flag_n_out [*2])
        else $error("ft rewind ready");
    a_rw_hold: assert property (s_rw |=> ##1 $stable(data_out))
        else $error("data moved in setup");
    a_pae_late: assert property (s_rw ##0 s_calm ##1 s_quiet |=> $stable(almost_empty_n_out))
        else $error("almost empty moved before second edge");
    a_paf_late: assert property (s_rw ##0 s_calm ##1 s_quiet |=> $stable(almost_full_n_out))
        else $error("almost full moved before second edge");
    a_ser_quiet: assert property (!offset_access_n_in && !serial_shift_enable_n_in
        && read_en_n_in && rewind_request_n_in && master_reset_n_in && partial_reset_n_in
        |=> $stable(data_out)) else $error("serial shift moved data");
    c_rw_std: cover property (s_rw ##0 !fallthrough_mode_out);
    c_rw_ft: cover property (s_rw ##0 fallthrough_mode_out);
    c_prs: cover property (!partial_reset_n_in && master_reset_n_in);
endmodule // ffrc_chk

bind ffrc_ctrl ffrc_chk #(.DATA_W(DATA_W)) ffrc_chk_inst (.*);

// ===== dv/ffrc_host.sv
/* host writer model: bursts of consecutive words
   assumes the bench requests bursts only after reset */
`timescale 1ns/1ps
module ffrc_host
    import ffrc_pkg::*;
#(parameter int DEPTH = 16) (
    input  wire logic                   clk_in,
    input  wire logic                   srst_in,
    input  wire logic                   go_in,
    input  wire logic [7:0]             n_in,
    input  wire logic [FFRC_DATA_W-1:0] base_in,
    output logic                        wen_n_out,
    output logic [FFRC_DATA_W-1:0]      wdata_out
);
    logic [7:0] cnt_q;
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            cnt_q <= '0;
            wen_n_out <= 1'b1;
        end else if (go_in && cnt_q == 0 && n_in != 0 && n_in <= DEPTH - 2) begin
            cnt_q <= n_in;
            wen_n_out <= 1'b0;
            wdata_out <= base_in;
        end else if (cnt_q > 1) begin
            cnt_q <= cnt_q - 8'h01;
            wdata_out <= wdata_out + 18'h00001;
        end else begin
            // idle bus keeps moving so a stale word never looks valid
            cnt_q <= '0;
            wen_n_out <= 1'b1;
            wdata_out <= ~wdata_out;
        end
    end
endmodule // ffrc_host

// ===== dv/ffrc_ctrl_test.sv
/* testbench of the reset and rewind controller
   assumes the full-depth store, so default offsets fit, and the host writer model */
`timescale 1ns/1ps
module ffrc_ctrl_test
    import ffrc_pkg::*;
;
    logic clk_in, srst_in, master_reset_n_in, partial_reset_n_in, rewind_request_n_in, go, look;
    logic write_en_n_in, read_en_n_in, offset_access_n_in, serial_shift_enable_n_in;
    logic mode_select_serial_in, empty_flag_n_out, full_flag_n_out, almost_empty_n_out;
    logic almost_full_n_out, half_full_n_out, fallthrough_mode_out;
    logic [17:0] data_in, data_out, base, e_v, f_v, exp_q[$];
    logic [7:0]  n;
    logic [31:0] rs;
    int          fails, cmp_count;
    ffrc_ctrl #(.ADDR_W(FFRC_ADDR_W)) ffrc_ctrl_inst (.*);
    ffrc_host #(.DEPTH(1 << FFRC_ADDR_W)) ffrc_host_inst (.clk_in(clk_in), .srst_in(srst_in),
        .go_in(go),
        .n_in(n), .base_in(base), .wen_n_out(write_en_n_in), .wdata_out(data_in));
    function automatic logic [31:0] xs(input logic [31:0] v);
        v ^= v << 13;
        v ^= v >> 17;
        v ^= v << 5;
        return v;
    endfunction
    task automatic chk(input string nm, input logic [17:0] e, input logic [17:0] g);
        cmp_count++;
        if (g !== e) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge clk_in);
    endtask
    // order: empty, full, almost empty, almost full, half full, mode
    task automatic flags(input logic [5:0] e);
        @(negedge clk_in);
        chk("flags", e, {empty_flag_n_out, full_flag_n_out, almost_empty_n_out,
            almost_full_n_out, half_full_n_out, fallthrough_mode_out});
        chk("data_out", 18'h00000, data_out);
    endtask
    task automatic rd(input logic [17:0] e);
        @(posedge clk_in);
        read_en_n_in <= 1'b0;
        @(posedge clk_in);
        read_en_n_in <= 1'b1;
        exp_q.push_back(e);
        look <= 1'b1;
        @(posedge clk_in);
        look <= 1'b0;
    endtask
    task automatic rb(input logic [17:0] a, input logic [17:0] b);
        @(posedge clk_in);
        offset_access_n_in <= 1'b0;
        rd(a);
        rd(b);
        offset_access_n_in <= 1'b1;
    endtask
    task automatic wr(input logic [7:0] k);
        rs = xs(rs);
        @(posedge clk_in);
        go <= 1'b1;
        n <= k;
        base <= rs[17:0];
        @(posedge clk_in);
        go <= 1'b0;
    endtask
    task automatic rew;
        @(posedge clk_in);
        rewind_request_n_in <= 1'b0;
        @(posedge clk_in);
        rewind_request_n_in <= 1'b1;
        @(negedge clk_in);
    endtask
    task automatic pr;
        @(posedge clk_in);
        partial_reset_n_in <= 1'b0;
        @(posedge clk_in);
        partial_reset_n_in <= 1'b1;
    endtask
    always @(negedge clk_in) begin
        if (look === 1'b1) chk("data_out", exp_q.pop_front(), data_out);
    end
    initial begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end
    initial begin
        #20000;
        fails++;
        end_of_test;
    end
    initial begin
        {srst_in, master_reset_n_in, partial_reset_n_in, rewind_request_n_in} = 4'hF;
        {read_en_n_in, serial_shift_enable_n_in, offset_access_n_in} = 3'b110;
        {mode_select_serial_in, go, look, n, base, rs} = '0;
        rs = 32'h00000024;
        tick(4);
        srst_in <= 1'b0;
        flags(6'b010110);
        rb(18'h0007F, 18'h0007F);
        wr(3);
        tick(6);
        rd(base);
        rd(base + 18'h1);
        rd(base + 18'h2);
        rew;
        chk("empty", 18'h0, empty_flag_n_out);
        tick(3);
        @(negedge clk_in);
        chk("empty", 18'h1, empty_flag_n_out);
        rd(base);
        pr;
        flags(6'b010110);
        rb(18'h0007F, 18'h0007F);
        $display("standard mode done");
        @(posedge clk_in);
        {mode_select_serial_in, offset_access_n_in, master_reset_n_in} <= 3'b110;
        @(posedge clk_in);
        {mode_select_serial_in, master_reset_n_in} <= 2'b01;
        flags(6'b100111);
        rb(18'h003FF, 18'h003FF);
        wr(2);
        tick(3);
        @(negedge clk_in);
        chk("data_out", 18'h003FF, data_out);
        @(negedge clk_in);
        chk("data_out", base, data_out);
        rd(base + 18'h1);
        rew;
        chk("ready", 18'h1, empty_flag_n_out);
        tick(3);
        @(negedge clk_in);
        chk("ready", 18'h0, empty_flag_n_out);
        chk("data_out", base, data_out);
        pr;
        flags(6'b100111);
        $display("fall-through mode done");
        rs = xs(rs);
        e_v = {3'b000, rs[14:0]};
        rs = xs(rs);
        f_v = {3'b000, rs[14:0]};
        @(posedge clk_in);
        {offset_access_n_in, serial_shift_enable_n_in} <= 2'b00;
        for (int i = 0; i < 30; i++) begin
            mode_select_serial_in <= (i < 15) ? e_v[i] : f_v[i - 15];
            @(posedge clk_in);
        end
        {offset_access_n_in, serial_shift_enable_n_in} <= 2'b11;
        rb(e_v, f_v);
        $display("serial load done");
        tick(3);
        end_of_test;
    end
endmodule // ffrc_ctrl_test
